// ---- hw/bus_strobe_consts.vh ----
// Constants for the bus strobe and reset control block
`ifndef BUS_STROBE_CONSTS_VH
`define BUS_STROBE_CONSTS_VH
// Oscillator input cycles per system clock output cycle
`define OSC_DIV 4
`define DIV_W 2
`define DIV_LAST 2'h3
`define DIV_HALF 2'h2
// Least reset hold, in device clock cycles
`define RESET_MIN_CYC 5
// Phase inside a machine cycle
`define PH_W 2
`define PH_ADDR 2'h0
`define PH_STROBE 2'h1
`define PH_HOLD 2'h2
`define PH_END 2'h3
// Operation request codes
`define OP_W 2
`define OP_FETCH 2'h0
`define OP_TABLE_WRITE_INSTR 2'h1
`define OP_IN 2'h2
`define OP_OUT 2'h3
`define ADDR_W 16
`define DATA_W 16
`define ADDR_ZERO 16'h0000
`define DATA_ZERO 16'h0000
`endif

// ---- hw/osc_quarter_div.v ----
// Divider that makes the quarter-rate system clock and machine-cycle phase
`timescale 1ns/1ps
`include "bus_strobe_consts.vh"
module osc_quarter_div (
  input wire clk_i,
  input wire rst_n_i,
  input wire run_i,
  output reg clk_out_o,
  output wire [`DIV_W-1:0] phase_o,
  output wire cycle_end_o
);
  reg [`DIV_W-1:0] cnt_q;
  reg [`DIV_W-1:0] cnt_d;

  always @* begin
    cnt_d = cnt_q + 2'h1;
  end

  // The output clock keeps running while run_i is low; only the phase is held
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 2'h0;
      clk_out_o <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      clk_out_o <= (cnt_d < `DIV_HALF); // RULE11
    end
  end

  assign phase_o = run_i ? cnt_q : `PH_END;
  assign cycle_end_o = (cnt_q == `DIV_LAST);
endmodule

// ---- hw/bus_strobe_reset_ctrl.v ----
// Bus strobe, reset sequencing and clock output control of the processor
`timescale 1ns/1ps
`include "bus_strobe_consts.vh"
// Functional notes
// RULE1: Fetch strobe low on every instruction fetch
// RULE2: Fetch low holds other three strobes high
// RULE3: Table-write strobe only on table write, drives data
// RULE4: Table-write low holds other strobes high
// RULE5: Host holds reset at least five cycles
// RULE6: Reset forces strobes high, releases data
// RULE7: PC and address cleared after one cycle
// RULE8: Reset disables interrupts, clears interrupt flags
// RULE9: Reset keeps overflow mode unchanged
// RULE10: Reset state held for any duration
// RULE11: System clock out is quarter of oscillator
// RULE12: Execution resumes one cycle after release
// RULE13: Reset input synchronised to the clock
// RULE14: Port read strobe only on input instruction
// RULE15: Port write strobe only on output instruction
module bus_strobe_reset_ctrl (
  input wire CLK_I,
  input wire RESET_N_I,
  input wire INIT_IN_N_I,
  input wire [`OP_W-1:0] OP_I,
  input wire OP_VALID_I,
  input wire [`ADDR_W-1:0] NEXT_PC_I,
  input wire [`ADDR_W-1:0] OP_ADDR_I,
  input wire [`DATA_W-1:0] WR_DATA_I,
  input wire [`DATA_W-1:0] DATA_IN_I,
  input wire INT_EDGE_I,
  input wire INT_ACK_I,
  input wire INT_EN_SET_I,
  input wire OVM_SET_I,
  input wire OVM_VAL_I,
  output reg PROGRAM_FETCH_STROBE_N_O,
  output reg TABLE_WRITE_STROBE_N_O,
  output reg PORT_WRITE_STROBE_N_O,
  output reg PORT_READ_STROBE_N_O,
  output reg [`ADDR_W-1:0] ADDR_O,
  output reg [`ADDR_W-1:0] PC_O,
  output reg [`DATA_W-1:0] DATA_O,
  output reg DATA_OE_O,
  output reg [`DATA_W-1:0] RD_DATA_O,
  output reg OP_DONE_O,
  output reg IN_RESET_O,
  output reg INT_ENABLE_O,
  output reg INTERRUPT_FLAG_REG_O,
  output reg OVERFLOW_MODE_O,
  output reg SYS_CLOCK_OUT_O
);
  // ----------------------------------------
  // Reset synchroniser and sequencing
  // ----------------------------------------
  localparam SEQ_RESET = 3'b001;
  localparam SEQ_CLEAR = 3'b010;
  localparam SEQ_RUN = 3'b100;

  reg init_meta_q;
  reg init_sync_q;
  reg [2:0] seq_q;
  reg [2:0] seq_d;
  reg [`OP_W-1:0] op_q;
  reg busy_q;
  wire sys_clk_w;
  wire [`DIV_W-1:0] phase_w;
  wire cycle_end_w;
  wire running_w;

  // Two flops; an external reset edge may land anywhere in a cycle
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      init_meta_q <= 1'b0;
      init_sync_q <= 1'b0;
    end else begin
      init_meta_q <= INIT_IN_N_I; // RULE13
      init_sync_q <= init_meta_q; // RULE13
    end
  end

  // No counter limits how long reset may be held
  always @* begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_RESET: begin
        if (init_sync_q && cycle_end_w) begin
          seq_d = SEQ_CLEAR;
        end
      end
      SEQ_CLEAR: begin
        if (!init_sync_q) begin
          seq_d = SEQ_RESET;
        end else if (cycle_end_w) begin
          seq_d = SEQ_RUN; // RULE12
        end
      end
      SEQ_RUN: begin
        if (!init_sync_q) begin
          seq_d = SEQ_RESET;
        end
      end
      default: begin
        seq_d = SEQ_RESET;
      end
    endcase
  end

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      seq_q <= SEQ_RESET;
    end else begin
      seq_q <= seq_d; // RULE10
    end
  end

  assign running_w = (seq_q == SEQ_RUN);

  osc_quarter_div u_div (
    .clk_i(CLK_I),
    .rst_n_i(RESET_N_I),
    .run_i(running_w),
    .clk_out_o(sys_clk_w),
    .phase_o(phase_w),
    .cycle_end_o(cycle_end_w)
  );

  // ----------------------------------------
  // Strobe decode
  // ----------------------------------------
  // One strobe at most can ever be low, since one op code is held
  function strobe_low;
    input [`OP_W-1:0] op;
    input [`OP_W-1:0] kind;
    input [`DIV_W-1:0] ph;
    input active;
    begin
      strobe_low = active && (op == kind) &&
        ((ph == `PH_STROBE) || (ph == `PH_HOLD));
    end
  endfunction

  // ----------------------------------------
  // Bus cycle, strobes and data bus
  // ----------------------------------------
  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      op_q <= `OP_FETCH;
      busy_q <= 1'b0;
      PROGRAM_FETCH_STROBE_N_O <= 1'b1;
      TABLE_WRITE_STROBE_N_O <= 1'b1;
      PORT_WRITE_STROBE_N_O <= 1'b1;
      PORT_READ_STROBE_N_O <= 1'b1;
      ADDR_O <= `ADDR_ZERO;
      PC_O <= `ADDR_ZERO;
      DATA_O <= `DATA_ZERO;
      DATA_OE_O <= 1'b0;
      RD_DATA_O <= `DATA_ZERO;
      OP_DONE_O <= 1'b0;
      IN_RESET_O <= 1'b1;
      SYS_CLOCK_OUT_O <= 1'b1;
    end else begin
      SYS_CLOCK_OUT_O <= sys_clk_w; // RULE11
      IN_RESET_O <= !running_w;
      OP_DONE_O <= 1'b0;
      if (!running_w) begin
        busy_q <= 1'b0;
        PROGRAM_FETCH_STROBE_N_O <= 1'b1; // RULE6
        TABLE_WRITE_STROBE_N_O <= 1'b1; // RULE6
        PORT_WRITE_STROBE_N_O <= 1'b1; // RULE6
        PORT_READ_STROBE_N_O <= 1'b1; // RULE6
        DATA_OE_O <= 1'b0; // RULE6
        // Cleared once the synchronised reset is seen, so a long hold shows zero
        PC_O <= `ADDR_ZERO; // RULE7
        ADDR_O <= `ADDR_ZERO; // RULE7
      end else begin
        if (phase_w == `PH_ADDR) begin
          busy_q <= OP_VALID_I;
          op_q <= OP_VALID_I ? OP_I : `OP_FETCH;
          // Fetches use the PC; other operations drive OP_ADDR_I unchanged on all address lines
          if (OP_VALID_I && (OP_I == `OP_FETCH)) begin
            ADDR_O <= PC_O;
          end else if (OP_VALID_I) begin
            ADDR_O <= OP_ADDR_I;
          end
          if (OP_VALID_I && (OP_I == `OP_TABLE_WRITE_INSTR || OP_I == `OP_OUT)) begin
            DATA_O <= WR_DATA_I;
          end
        end
        PROGRAM_FETCH_STROBE_N_O <= !strobe_low(op_q, `OP_FETCH, phase_w, busy_q); // RULE1 RULE2
        TABLE_WRITE_STROBE_N_O <= !strobe_low(op_q, `OP_TABLE_WRITE_INSTR, phase_w, busy_q); // RULE3 RULE4
        PORT_READ_STROBE_N_O <= !strobe_low(op_q, `OP_IN, phase_w, busy_q); // RULE14
        PORT_WRITE_STROBE_N_O <= !strobe_low(op_q, `OP_OUT, phase_w, busy_q); // RULE15
        // Data driven only under a write strobe
        DATA_OE_O <= strobe_low(op_q, `OP_TABLE_WRITE_INSTR, phase_w, busy_q) ||
          strobe_low(op_q, `OP_OUT, phase_w, busy_q); // RULE3
        if (busy_q && phase_w == `PH_END) begin
          OP_DONE_O <= 1'b1;
          busy_q <= 1'b0;
          if (op_q == `OP_IN) begin
            RD_DATA_O <= DATA_IN_I;
          end
          if (op_q == `OP_FETCH) begin
            PC_O <= NEXT_PC_I;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Interrupt enable, flag and overflow mode
  // ----------------------------------------
  // Overflow mode has no reset term so a restart keeps it
  always @(posedge CLK_I) begin
    if (OVM_SET_I && running_w) begin
      OVERFLOW_MODE_O <= OVM_VAL_I;
    end else begin
      OVERFLOW_MODE_O <= OVERFLOW_MODE_O; // RULE9
    end
  end

  always @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      INT_ENABLE_O <= 1'b0;
      INTERRUPT_FLAG_REG_O <= 1'b0;
    end else if (!running_w) begin
      INT_ENABLE_O <= 1'b0; // RULE8
      INTERRUPT_FLAG_REG_O <= 1'b0; // RULE8
    end else begin
      if (INT_EN_SET_I) begin
        INT_ENABLE_O <= 1'b1;
      end else if (INT_ACK_I) begin
        INT_ENABLE_O <= 1'b0;
      end
      // A new edge wins over a grant in the same cycle
      if (INT_EDGE_I) begin
        INTERRUPT_FLAG_REG_O <= 1'b1;
      end else if (INT_ACK_I) begin
        INTERRUPT_FLAG_REG_O <= 1'b0;
      end
    end
  end
endmodule

// ---- bench/strobe_ctrl_assertions.sv ----
// Concurrent checks on the strobe, reset and clock outputs of the control block
`timescale 1ns/1ps
module strobe_ctrl_checker (
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  input wire logic INIT_IN_N_I,
  input wire logic OVM_SET_I,
  input wire logic PROGRAM_FETCH_STROBE_N_O,
  input wire logic TABLE_WRITE_STROBE_N_O,
  input wire logic PORT_WRITE_STROBE_N_O,
  input wire logic PORT_READ_STROBE_N_O,
  input wire logic [15:0] ADDR_O,
  input wire logic [15:0] PC_O,
  input wire logic DATA_OE_O,
  input wire logic IN_RESET_O,
  input wire logic INT_ENABLE_O,
  input wire logic INTERRUPT_FLAG_REG_O,
  input wire logic OVERFLOW_MODE_O,
  input wire logic SYS_CLOCK_OUT_O
);
  wire f = PROGRAM_FETCH_STROBE_N_O;
  wire t = TABLE_WRITE_STROBE_N_O;
  wire w = PORT_WRITE_STROBE_N_O;
  wire r = PORT_READ_STROBE_N_O;
  // --------
  // Checks
  // --------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  fetch_excl_a: assert property (!f |-> t && w && r)
    else $error("fetch strobe overlaps another strobe");
  fetch_len_a: assert property ($fell(f) |=> !f ##1 f)
    else $error("fetch strobe width wrong");
  table_excl_a: assert property (!t |-> f && w && r && DATA_OE_O)
    else $error("table write strobe not exclusive or bus idle");
  read_excl_a: assert property (!r |-> f && t && w)
    else $error("port read strobe overlaps another strobe");
  write_excl_a: assert property (!w |-> f && t && r && DATA_OE_O)
    else $error("port write strobe not exclusive or bus idle");
  init_force_a: assert property (!INIT_IN_N_I [*5] |-> f && t && w && r && !DATA_OE_O && IN_RESET_O)
    else $error("reset does not quiet the bus");
  int_clear_a: assert property (!INIT_IN_N_I [*5] |-> !INT_ENABLE_O && !INTERRUPT_FLAG_REG_O)
    else $error("reset leaves interrupt state");
  pc_reset_a: assert property (!INIT_IN_N_I [*5] |-> PC_O == 16'h0000 && ADDR_O == 16'h0000)
    else $error("pc or address not cleared during reset");
  pc_clear_a: assert property ($fell(IN_RESET_O) |-> PC_O == 16'h0000 && ADDR_O == 16'h0000)
    else $error("pc or address not cleared at start");
  ovm_keep_a: assert property (IN_RESET_O && !OVM_SET_I |=> $stable(OVERFLOW_MODE_O))
    else $error("overflow mode changed in reset");
  clk_quarter_a: assert property ($rose(SYS_CLOCK_OUT_O) |=> SYS_CLOCK_OUT_O ##1 !SYS_CLOCK_OUT_O [*2] ##1 SYS_CLOCK_OUT_O)
    else $error("clock out not a quarter of input");
  cover property ($fell(f));
  cover property ($fell(t));
  cover property ($fell(r));
  cover property ($fell(w));
endmodule
bind bus_strobe_reset_ctrl strobe_ctrl_checker chk (.*);

// ---- bench/ext_port_model.sv ----
// Model of a peripheral input port driving the data bus under the port read strobe
`timescale 1ns/1ps
module ext_port_model (
  input wire logic clk_i,
  input wire logic port_read_strobe_n_i,
  input wire logic [15:0] addr_i,
  output logic [15:0] data_o
);
  logic [15:0] last_q = 16'h0000;
  // Released bus toggles every cycle so a stale capture cannot pass
  always @(posedge clk_i) begin
    last_q <= ~data_o;
  end
  assign data_o = port_read_strobe_n_i ? last_q : (addr_i ^ 16'h5a5a);
endmodule

// ---- bench/bus_strobe_reset_ctrl_bench.sv ----
// Self-checking testbench for the bus strobe and reset control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module bus_strobe_reset_ctrl_bench;
  logic CLK_I = 1'h0, RESET_N_I = 1'h0, INIT_IN_N_I = 1'h1, OP_VALID_I = 1'h0;
  logic INT_EDGE_I = 1'h0, INT_ACK_I = 1'h0, INT_EN_SET_I = 1'h0;
  logic OVM_SET_I = 1'h1, OVM_VAL_I = 1'h1;
  logic [1:0] OP_I = 2'h0;
  logic [15:0] NEXT_PC_I = 16'h0000, OP_ADDR_I = 16'h0000, WR_DATA_I = 16'h0000;
  wire [15:0] ADDR_O, PC_O, DATA_O, RD_DATA_O, DATA_IN_I;
  wire PROGRAM_FETCH_STROBE_N_O, TABLE_WRITE_STROBE_N_O, PORT_WRITE_STROBE_N_O;
  wire PORT_READ_STROBE_N_O, DATA_OE_O, OP_DONE_O, IN_RESET_O, INT_ENABLE_O;
  wire INTERRUPT_FLAG_REG_O, OVERFLOW_MODE_O, SYS_CLOCK_OUT_O;
  int errors = 0, tests_run = 0;
  bus_strobe_reset_ctrl DUT (.*);
  ext_port_model mem (.clk_i(CLK_I), .port_read_strobe_n_i(PORT_READ_STROBE_N_O),
    .addr_i(ADDR_O), .data_o(DATA_IN_I));
  always #5 CLK_I = ~CLK_I;
  // --------
  // Scenarios
  // --------
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (IN_RESET_O !== 1'h0 && n < 40) begin
      @(negedge CLK_I);
      n++;
    end
    `CHK("left reset", 1'h0, IN_RESET_O)
    `CHK("pc at start", 16'h0000, PC_O)
    `CHK("addr at start", 16'h0000, ADDR_O)
  endtask
  task automatic run_op(input logic [1:0] k, input logic [15:0] a, input logic [15:0] d);
    int low[4];
    int n;
    logic [3:0] s;
    logic [15:0] pc0;
    low = '{0, 0, 0, 0};
    n = 0;
    pc0 = PC_O;
    OP_I = k;
    OP_ADDR_I = a;
    WR_DATA_I = d;
    NEXT_PC_I = a + 16'h0001;
    OP_VALID_I = 1'h1;
    do begin
      @(negedge CLK_I);
      n++;
      s = {PORT_WRITE_STROBE_N_O, PORT_READ_STROBE_N_O, TABLE_WRITE_STROBE_N_O,
        PROGRAM_FETCH_STROBE_N_O};
      for (int i = 0; i < 4; i++) if (s[i] === 1'h0) low[i]++;
      if (k[0] && s[k] === 1'h0) `CHK("write data", d, DATA_O)
      if (s[k] === 1'h0) `CHK("address", (k == 2'h0) ? pc0 : a, ADDR_O)
    end while (OP_DONE_O !== 1'h1 && n < 12);
    `CHK("op done", 1'h1, OP_DONE_O)
    for (int i = 0; i < 4; i++) `CHK("strobe cycles", (i == k) ? 2 : 0, low[i])
    if (k == 2'h2) `CHK("read data", a ^ 16'h5a5a, RD_DATA_O)
    if (k == 2'h0) `CHK("pc after fetch", a + 16'h0001, PC_O)
  endtask
  task automatic init_reset();
    INT_EN_SET_I = 1'h1;
    INT_EDGE_I = 1'h1;
    @(negedge CLK_I);
    INT_EN_SET_I = 1'h0;
    INT_EDGE_I = 1'h0;
    repeat (2) @(negedge CLK_I);
    `CHK("int enable set", 1'h1, INT_ENABLE_O)
    `CHK("int flag set", 1'h1, INTERRUPT_FLAG_REG_O)
    INIT_IN_N_I = 1'h0;
    repeat (30) @(negedge CLK_I);
    `CHK("strobes idle", 4'hf, {PROGRAM_FETCH_STROBE_N_O, TABLE_WRITE_STROBE_N_O,
      PORT_WRITE_STROBE_N_O, PORT_READ_STROBE_N_O})
    `CHK("bus released", 1'h0, DATA_OE_O)
    `CHK("held in reset", 1'h1, IN_RESET_O)
    `CHK("pc in reset", 16'h0000, PC_O)
    `CHK("addr in reset", 16'h0000, ADDR_O)
    `CHK("int state", 2'h0, {INT_ENABLE_O, INTERRUPT_FLAG_REG_O})
    `CHK("overflow mode", 1'h1, OVERFLOW_MODE_O)
    INIT_IN_N_I = 1'h1;
    wait_run();
  endtask
  task automatic clock_rate();
    int rises;
    logic prev;
    rises = 0;
    prev = SYS_CLOCK_OUT_O;
    repeat (40) begin
      @(negedge CLK_I);
      if (SYS_CLOCK_OUT_O === 1'h1 && prev === 1'h0) rises++;
      prev = SYS_CLOCK_OUT_O;
    end
    `CHK("clock out rises", 10, rises)
  endtask
  // --------
  // Main sequence and watchdog
  // --------
  initial begin
    repeat (3) @(negedge CLK_I);
    RESET_N_I = 1'h1;
    wait_run();
    repeat (2) @(negedge CLK_I);
    OVM_SET_I = 1'h0;
    for (int k = 0; k < 4; k++) run_op(k[1:0], 16'h0010 + k[15:0], 16'hc3a0 + k[15:0]);
    OP_VALID_I = 1'h0;
    init_reset();
    run_op(2'h0, 16'h0042, 16'h0000);
    OP_VALID_I = 1'h0;
    clock_rate();
    end_of_test();
  end
  // Whole run needs about 125 cycles; sixteen times that means a hang
  initial begin
    #20000;
    errors++;
    end_of_test();
  end
endmodule
